// ===== rtl/ldc_params.svh
// Constants of the LED driver control block: timing, layout, offsets.
// Assumes a 25 MHz system clock; included by the package and modules.
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
`define LDC_CLK_NS 40
`define LDC_DET_NS 1000
`define LDC_DET_CYC ((`LDC_DET_NS + `LDC_CLK_NS - 1) / `LDC_CLK_NS)
`define LDC_STEP_NS 20
`define LDC_SPAN_NS 300
`define LDC_SPAN_CYC (`LDC_SPAN_NS / `LDC_CLK_NS)
`define LDC_NCH 16
`define LDC_DOT_W 6
`define LDC_DOT_BITS 96
`define LDC_DOT_RST 6'h3F
`define LDC_GS_W 12
`define LDC_GS_MAX 12'hFFF
`define LDC_SID_W 192
`define LDC_SID_OT 16
`define LDC_SID_DOT 24
`define LDC_LEN_GS 8'hC0
`define LDC_LEN_DC 8'h60
`define LDC_PIN_BLANK 0
`define LDC_PIN_SCLK 1
`define LDC_PIN_GSCLK 2
`define LDC_PIN_LATCH 3
`define LDC_PIN_TEMP 4
`define LDC_PIN_DSEL 5
`define LDC_PIN_MODE 6
`define LDC_PIN_LOW 8
`define LDC_PIN_W 24
`define LDC_ADDR_W 8
`define LDC_OFF_STATUS 8'h00
`define LDC_OFF_MASK 8'h04
`define LDC_OFF_CTRL 8'h08
`define LDC_OFF_SID 8'h0C
`define LDC_OFF_STATE 8'h10
`define LDC_EV_OT 0
`define LDC_EV_OPEN 1
`define LDC_EV_CAP 2
`define LDC_EV_W 3
`define LDC_RESP_OKAY 2'h0
`define LDC_RESP_SLVERR 2'h2
`endif

// ===== rtl/ldc_pkg.sv
// Types of the LED driver control block.
// Assumes ldc_params.svh is on the include path.
`include "ldc_params.svh"
package ldc_pkg;
	typedef enum logic [2:0] {
		LDC_MODE_GS = 3'h1,
		LDC_MODE_DC = 3'h2,
		LDC_MODE_PROG = 3'h4
	} ldc_mode_t;
	typedef struct packed {
		logic [`LDC_NCH-1:0][`LDC_SPAN_CYC:0] line;
		logic [`LDC_NCH-1:0][4:0] tmr;
		logic [`LDC_NCH-1:0] open;
	} ldc_stg_t;
	typedef struct packed {
		logic [`LDC_NCH-1:0][`LDC_DOT_W-1:0] mem;
		logic [`LDC_DOT_BITS-1:0] rd;
	} ldc_nv_t;
	typedef struct packed {
		logic [`LDC_PIN_W-1:0] s1;
		logic [`LDC_PIN_W-1:0] s2;
		logic [`LDC_PIN_W-1:0] s3;
		logic [`LDC_GS_W-1:0] gs_cnt;
		logic [`LDC_SID_OT:0] status_info_data;
		logic [`LDC_SID_W-1:0] sid_sh;
		logic fault;
		logic ot_prev;
		logic open_prev;
		logic nvw_prev;
		logic [`LDC_EV_W-1:0] status;
		logic [`LDC_EV_W-1:0] mask;
		logic inhibit;
		logic irq;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} ldc_top_t;
endpackage

// ===== rtl/ldc_nvstore.sv
// Non-volatile dot value store, one entry per channel.
// Assumes a one-cycle write pulse from the block's own clock domain.
`timescale 1ns/100ps
`include "ldc_params.svh"
module ldc_nvstore (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr,
	input wire logic [`LDC_DOT_BITS-1:0] wdata,
	output logic [`LDC_DOT_BITS-1:0] rdata
);
	ldc_pkg::ldc_nv_t q;
	ldc_pkg::ldc_nv_t d;

	always_comb begin
		d = q;
		if (wr) begin
			d.mem = wdata;
		end
		d.rd = q.mem;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q.mem <= {`LDC_NCH{`LDC_DOT_RST}};
			q.rd <= {`LDC_NCH{`LDC_DOT_RST}};
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rd;
endmodule

// ===== rtl/ldc_stagger.sv
// Staggered channel switching and open-LED detection per channel.
// Assumes requests already gated by inhibit and low inputs synchronised.
`timescale 1ns/100ps
`include "ldc_params.svh"
module ldc_stagger (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`LDC_NCH-1:0] drive_req,
	input wire logic [`LDC_NCH-1:0] chan_low,
	output logic [`LDC_NCH-1:0] sink_on,
	output logic [`LDC_NCH-1:0] open_flag
);
	localparam logic [4:0] DET = 5'(`LDC_DET_CYC);
	ldc_pkg::ldc_stg_t q;
	ldc_pkg::ldc_stg_t d;

	function automatic int tap(input int ch);
		return (ch * `LDC_STEP_NS) / `LDC_CLK_NS;
	endfunction

	always_comb begin
		d = q;
		sink_on = '0;
		for (int i = 0; i < `LDC_NCH; i++) begin
			d.line[i] = {q.line[i][`LDC_SPAN_CYC-1:0], drive_req[i]};
			sink_on[i] = q.line[i][tap(i)];
			if (!sink_on[i]) begin
				d.tmr[i] = '0;
			end else if (q.tmr[i] != DET) begin
				d.tmr[i] = q.tmr[i] + 5'h01;
			end
			d.open[i] = sink_on[i] && q.tmr[i] == DET && chan_low[i];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign open_flag = q.open;
endmodule

// ===== rtl/ldc_top.sv
// Control logic of a 16-channel LED sink driver: fault line, status
// capture and readout, staggered switching, blanking and mode select.
// Assumes all pin inputs are asynchronous to clk and the grayscale
// comparator that forms drive_req runs on clk.
`timescale 1ns/100ps
`include "ldc_params.svh"
module ldc_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic blank_pin,
	input wire logic gsclk,
	input wire logic sclk,
	input wire logic latch_strobe,
	input wire logic overtemp_in,
	input wire logic [1:0] mode_pin,
	input wire logic dot_source_select,
	input wire logic [`LDC_NCH-1:0] chan_low,
	input wire logic [`LDC_NCH-1:0] drive_req,
	input wire logic [`LDC_DOT_BITS-1:0] dot_reg_val,
	output logic [`LDC_NCH-1:0] channel_sink,
	output logic fault_out_n_o,
	output logic fault_out_n_oe,
	output logic overtemp_flag,
	output logic [`LDC_NCH-1:0] open_led_flag,
	output logic serial_shift_output,
	output logic [`LDC_DOT_BITS-1:0] dot_value,
	output logic dot_from_nv,
	output logic [7:0] shift_len,
	output logic [2:0] mode,
	output logic [`LDC_GS_W-1:0] gs_count,
	output logic irq,
	input wire logic [`LDC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`LDC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	ldc_pkg::ldc_top_t q;
	ldc_pkg::ldc_top_t d;
	ldc_pkg::ldc_mode_t mode_sel;
	logic [`LDC_PIN_W-1:0] pins;
	logic [`LDC_NCH-1:0] gated_req;
	logic [`LDC_NCH-1:0] open_flags;
	logic [`LDC_DOT_BITS-1:0] nv_val;
	logic [`LDC_EV_W-1:0] ev;
	logic blank;
	logic ot;
	logic any_open;
	logic nvw;
	logic wr_go;
	logic rd_go;
	logic rd_clr;

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	always_comb begin
		pins = '0;
		pins[`LDC_PIN_BLANK] = blank_pin;
		pins[`LDC_PIN_SCLK] = sclk;
		pins[`LDC_PIN_GSCLK] = gsclk;
		pins[`LDC_PIN_LATCH] = latch_strobe;
		pins[`LDC_PIN_TEMP] = overtemp_in;
		pins[`LDC_PIN_DSEL] = dot_source_select;
		pins[`LDC_PIN_MODE+1:`LDC_PIN_MODE] = mode_pin;
		pins[`LDC_PIN_LOW+`LDC_NCH-1:`LDC_PIN_LOW] = chan_low;
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// mode pin decode
	always_comb begin
		if (q.s2[`LDC_PIN_MODE+1]) begin
			mode_sel = ldc_pkg::LDC_MODE_PROG;
		end else if (q.s2[`LDC_PIN_MODE]) begin
			mode_sel = ldc_pkg::LDC_MODE_DC;
		end else begin
			mode_sel = ldc_pkg::LDC_MODE_GS;
		end
	end

	// ------------------------------------------------------------
	// Channel path
	// ------------------------------------------------------------
	// The software inhibit acts like the pin so a board without the
	// pin wired can still blank the outputs.
	assign blank = q.s2[`LDC_PIN_BLANK] | q.inhibit;
	// gate before the delay line
	// Gating ahead of the delay line costs up to eight cycles of light
	// after inhibit rises, but keeps a short pulse whole on every channel.
	assign gated_req = drive_req & ~{`LDC_NCH{blank}};

	ldc_stagger u_stagger (
		.clk(clk),
		.reset_n(reset_n),
		.drive_req(gated_req),
		.chan_low(q.s2[`LDC_PIN_LOW+`LDC_NCH-1:`LDC_PIN_LOW]),
		.sink_on(channel_sink),
		.open_flag(open_flags)
	);

	// ------------------------------------------------------------
	// Dot value source and store
	// ------------------------------------------------------------
	assign nvw = mode_sel == ldc_pkg::LDC_MODE_PROG && q.s2[`LDC_PIN_DSEL];

	ldc_nvstore u_nvstore (
		.clk(clk),
		.reset_n(reset_n),
		.wr(nvw & ~q.nvw_prev),
		.wdata(dot_reg_val),
		.rdata(nv_val)
	);

	assign dot_from_nv = ~q.s2[`LDC_PIN_DSEL];
	assign dot_value = dot_from_nv ? nv_val : dot_reg_val;
	assign shift_len = mode_sel == ldc_pkg::LDC_MODE_GS ?
		`LDC_LEN_GS : `LDC_LEN_DC;
	assign mode = mode_sel;

	// ------------------------------------------------------------
	// Events and bus handshakes
	// ------------------------------------------------------------
	assign ot = q.s2[`LDC_PIN_TEMP];
	assign any_open = |open_flags;
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
	assign rd_go = s_axi_arvalid & ~q.rvalid;
	assign rd_clr = rd_go && s_axi_araddr == `LDC_OFF_STATUS;

	always_comb begin
		ev = '0;
		ev[`LDC_EV_OT] = ot & ~q.ot_prev;
		ev[`LDC_EV_OPEN] = any_open & ~q.open_prev;
		ev[`LDC_EV_CAP] = ~q.s2[`LDC_PIN_LATCH] & q.s3[`LDC_PIN_LATCH];
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		// The first stage feeds only the second one.
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.ot_prev = ot;
		d.open_prev = any_open;
		d.nvw_prev = nvw;

		if (blank) begin
			d.gs_cnt = '0;
		end else if (q.s2[`LDC_PIN_GSCLK] && !q.s3[`LDC_PIN_GSCLK] &&
			q.gs_cnt != `LDC_GS_MAX) begin
			d.gs_cnt = q.gs_cnt + 12'h001;
		end

		d.fault = ot | (any_open & ~blank);

		if (ev[`LDC_EV_CAP]) begin
			d.status_info_data = {ot, open_flags};
			d.sid_sh = '0;
			d.sid_sh[`LDC_SID_OT:0] = {ot, open_flags};
			d.sid_sh[`LDC_SID_DOT+`LDC_DOT_BITS-1:`LDC_SID_DOT] = dot_value;
		end else if (q.s2[`LDC_PIN_SCLK] && !q.s3[`LDC_PIN_SCLK] &&
			mode_sel == ldc_pkg::LDC_MODE_GS) begin
			d.sid_sh = {q.sid_sh[`LDC_SID_W-2:0], 1'b0};
		end

		// A new event wins over the read that clears the old ones.
		d.status = (q.status & ~{`LDC_EV_W{rd_clr}}) | ev;

		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.bvalid = 1'b1;
			d.bresp = `LDC_RESP_OKAY;
			if (s_axi_awaddr == `LDC_OFF_MASK) begin
				if (s_axi_wstrb[0]) begin
					d.mask = s_axi_wdata[`LDC_EV_W-1:0];
				end
			end else if (s_axi_awaddr == `LDC_OFF_CTRL) begin
				if (s_axi_wstrb[0]) begin
					d.inhibit = s_axi_wdata[0];
				end
			end else if (s_axi_awaddr != `LDC_OFF_STATUS &&
				s_axi_awaddr != `LDC_OFF_SID &&
				s_axi_awaddr != `LDC_OFF_STATE) begin
				d.bresp = `LDC_RESP_SLVERR;
			end
		end
		d.irq = |(d.status & d.mask);

		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_go) begin
			d.rvalid = 1'b1;
			d.rresp = `LDC_RESP_OKAY;
			d.rdata = '0;
			if (s_axi_araddr == `LDC_OFF_STATUS) begin
				d.rdata[`LDC_EV_W-1:0] = q.status;
			end else if (s_axi_araddr == `LDC_OFF_MASK) begin
				d.rdata[`LDC_EV_W-1:0] = q.mask;
			end else if (s_axi_araddr == `LDC_OFF_CTRL) begin
				d.rdata[0] = q.inhibit;
			end else if (s_axi_araddr == `LDC_OFF_SID) begin
				d.rdata[`LDC_SID_OT:0] = q.status_info_data;
			end else if (s_axi_araddr == `LDC_OFF_STATE) begin
				d.rdata[`LDC_GS_W-1:0] = q.gs_cnt;
				d.rdata[14:12] = mode_sel;
				d.rdata[15] = q.fault;
				d.rdata[16] = blank;
			end else begin
				d.rresp = `LDC_RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Open drain: the line is only ever pulled low, never driven high.
	assign fault_out_n_o = 1'b0;
	assign fault_out_n_oe = q.fault;
	assign overtemp_flag = ot;
	assign open_led_flag = open_flags;
	assign serial_shift_output = q.sid_sh[`LDC_SID_W-1];
	assign gs_count = q.gs_cnt;
	assign irq = q.irq;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
endmodule

// ===== verification/ldc_checker.sv
// Assertions on the fault line, inhibit, stagger and mode pins.
// Assumes it is bound into ldc_top and sees only that module's ports.
`timescale 1ns/100ps
module ldc_checker (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic blank_pin,
	input wire logic [1:0] mode_pin,
	input wire logic dot_source_select,
	input wire logic [15:0] channel_sink,
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe,
	input wire logic overtemp_flag,
	input wire logic [15:0] open_led_flag,
	input wire logic dot_from_nv,
	input wire logic [7:0] shift_len,
	input wire logic [2:0] mode,
	input wire logic [11:0] gs_count
);
	logic [3:0] held_q;
	// ----------
	// Helper
	// ----------
	// Saturates so that a long inhibit stays covered.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			held_q <= 4'h0;
		else if (!blank_pin)
			held_q <= 4'h0;
		else if (held_q != 4'hF)
			held_q <= held_q + 4'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_inhibit;
		blank_pin [*5];
	endsequence
	sequence s_quiet;
		(!overtemp_flag && open_led_flag == 16'h0000) [*3];
	endsequence
	// ----------
	// Properties
	// ----------
	property p_low_only;
		fault_out_n_o == 1'h0;
	endproperty
	property p_ot_fault;
		$rose(overtemp_flag) |-> ##[0:2] fault_out_n_oe;
	endproperty
	property p_release;
		s_quiet |-> !fault_out_n_oe;
	endproperty
	// Inhibit settles through the synchroniser before the mask applies.
	property p_masked;
		(blank_pin && !overtemp_flag) [*5] |-> !fault_out_n_oe;
	endproperty
	property p_dark;
		held_q >= 4'hC |-> channel_sink == 16'h0000;
	endproperty
	property p_clear;
		s_inhibit |-> gs_count == 12'h000;
	endproperty
	property p_step;
		gs_count != $past(gs_count) |->
			(gs_count == $past(gs_count) + 12'h001 || gs_count == 12'h000);
	endproperty
	property p_stag_on;
		$rose(channel_sink[15]) |-> $past(channel_sink[0], 7);
	endproperty
	property p_stag_off;
		$fell(channel_sink[15]) |-> !$past(channel_sink[0], 7);
	endproperty
	property p_mode;
		(mode_pin == 2'h0) [*3] |-> shift_len == 8'hC0 && mode == 3'h1;
	endproperty
	property p_src;
		dot_source_select [*4] |-> !dot_from_nv;
	endproperty
	a_low_only: assert property (p_low_only) else $error("line driven high");
	a_ot_fault: assert property (p_ot_fault) else $error("no heat fault");
	a_release: assert property (p_release) else $error("line not freed");
	a_masked: assert property (p_masked) else $error("open not masked");
	a_dark: assert property (p_dark) else $error("sink on in inhibit");
	a_clear: assert property (p_clear) else $error("count not cleared");
	a_step: assert property (p_step) else $error("count jumped");
	a_stag_on: assert property (p_stag_on) else $error("on skew");
	a_stag_off: assert property (p_stag_off) else $error("off skew");
	a_mode: assert property (p_mode) else $error("wrong mode");
	a_src: assert property (p_src) else $error("wrong source");
endmodule
bind ldc_top ldc_checker u_chk (.clk(clk), .reset_n(reset_n),
	.blank_pin(blank_pin), .mode_pin(mode_pin),
	.dot_source_select(dot_source_select), .channel_sink(channel_sink),
	.fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe),
	.overtemp_flag(overtemp_flag), .open_led_flag(open_led_flag),
	.dot_from_nv(dot_from_nv), .shift_len(shift_len), .mode(mode),
	.gs_count(gs_count));

// ===== verification/ldc_ctrl_model.sv
// Model of the external controller: strobe, status shift, fault line.
// Assumes the shared fault line has a pull-up and no other driver.
`timescale 1ns/100ps
module ldc_ctrl_model (
	input wire logic fault_out_n_o,
	input wire logic fault_out_n_oe,
	input wire logic serial_shift_output,
	output logic latch_strobe,
	output logic sclk,
	output logic fault_wire,
	output logic [191:0] rx
);
	assign fault_wire = fault_out_n_oe ? fault_out_n_o : 1'h1;
	initial begin
		latch_strobe = 1'h0;
		sclk = 1'h0;
		rx = '0;
	end
	// strobe, then shift
	// The clock stands low between frames, as a real controller leaves it.
	task automatic read_status();
		// Move off the sampling edge so every pin change and every sample
		// of the serial output falls between clock edges.
		#10;
		latch_strobe = 1'h1;
		#320;
		latch_strobe = 1'h0;
		#480;
		for (int i = 0; i < 192; i++) begin
			rx = {rx[190:0], serial_shift_output};
			sclk = 1'h1;
			#160;
			sclk = 1'h0;
			#160;
		end
	endtask
endmodule

// ===== verification/led_driver_error_blank_mode_control_tb_top.sv
// Top bench of the LED driver control block: modes, inhibit, faults, bus.
// Assumes the controller model and the bound checker are compiled with it.
`timescale 1ns/100ps
module led_driver_error_blank_mode_control_tb_top;
	typedef struct packed {
		logic [1:0] mp;
		logic ds;
		logic [7:0] len;
		logic [2:0] md;
	} ldc_row_t;
	localparam logic [95:0] DOTS = 96'h5A5A0F0F123456789ABCDEF0;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic blank_pin = 1'h1;
	logic gsclk = 1'h0;
	logic overtemp_in = 1'h0;
	logic dot_source_select = 1'h0;
	logic [1:0] mode_pin = 2'h0;
	logic [15:0] chan_low = 16'h0000;
	logic [15:0] drive_req = 16'h0000;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic sclk, latch_strobe, fault_wire, fault_out_n_o, fault_out_n_oe;
	logic overtemp_flag, serial_shift_output, dot_from_nv, irq;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [191:0] rx;
	logic [15:0] channel_sink, open_led_flag;
	logic [95:0] dot_value;
	logic [7:0] shift_len;
	logic [2:0] mode;
	logic [11:0] gs_count;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int failures = 0;
	int checks_done = 0;
	int n;
	ldc_row_t rows [6] = '{'{2'h0, 1'h0, 8'hC0, 3'h1},
		'{2'h0, 1'h1, 8'hC0, 3'h1}, '{2'h1, 1'h0, 8'h60, 3'h2},
		'{2'h1, 1'h1, 8'h60, 3'h2}, '{2'h2, 1'h0, 8'h60, 3'h4},
		'{2'h3, 1'h0, 8'h60, 3'h4}};
	ldc_top DUT (.clk, .reset_n, .blank_pin, .gsclk, .sclk, .latch_strobe,
		.overtemp_in, .mode_pin, .dot_source_select, .chan_low, .drive_req,
		.dot_reg_val(DOTS), .channel_sink, .fault_out_n_o, .fault_out_n_oe,
		.overtemp_flag, .open_led_flag, .serial_shift_output, .dot_value,
		.dot_from_nv, .shift_len, .mode, .gs_count, .irq, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	ldc_ctrl_model ctl (.fault_out_n_o, .fault_out_n_oe, .serial_shift_output,
		.latch_strobe, .sclk, .fault_wire, .rx);
	always #20 clk = ~clk;
	// ----------
	// Tasks
	// ----------
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [191:0] e,
		input logic [191:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do cyc(1); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do cyc(1); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk("bresp", r, s_axi_bresp);
		cyc(1);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do cyc(1); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do cyc(1); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
		cyc(1);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------
	// Sequence
	// ----------
	initial begin
		cyc(12);
		reset_n <= 1'h1;
		cyc(4);
		chk("oe", 0, fault_out_n_oe);
		foreach (rows[i]) begin
			mode_pin <= rows[i].mp;
			dot_source_select <= rows[i].ds;
			cyc(6);
			chk("len", rows[i].len, shift_len);
			chk("mode", rows[i].md, mode);
			chk("nv", !rows[i].ds, dot_from_nv);
			chk("dot", rows[i].ds ? DOTS : {16{6'h3F}}, dot_value);
		end
		dot_source_select <= 1'h1;
		cyc(6);
		mode_pin <= 2'h0;
		dot_source_select <= 1'h0;
		cyc(6);
		chk("store", DOTS, dot_value);
		$display("done modes");
		blank_pin <= 1'h0;
		cyc(4);
		repeat (3) begin
			gsclk <= 1'h1;
			cyc(3);
			gsclk <= 1'h0;
			cyc(3);
		end
		chk("gs", 12'h003, gs_count);
		blank_pin <= 1'h1;
		cyc(6);
		chk("gs", 12'h000, gs_count);
		drive_req <= 16'hFFFF;
		chan_low <= 16'h0008;
		blank_pin <= 1'h0;
		n = 0;
		while (!channel_sink[0] && n < 20) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (!channel_sink[15] && n < 20) begin
			cyc(1);
			n++;
		end
		chk("skew", 7, n);
		chk("early", 16'h0000, open_led_flag);
		cyc(40);
		chk("open", 16'h0008, open_led_flag);
		chk("line", 0, fault_wire);
		chk("sink", 16'hFFFF, channel_sink);
		ctl.read_status();
		cyc(1);
		chk("sid", {72'h0, DOTS, 8'h00, 16'h0008}, rx);
		blank_pin <= 1'h1;
		chan_low <= 16'h0000;
		cyc(14);
		chk("line", 1, fault_wire);
		chk("sink", 16'h0000, channel_sink);
		overtemp_in <= 1'h1;
		cyc(5);
		chk("line", 0, fault_wire);
		chk("irq", 0, irq);
		overtemp_in <= 1'h0;
		cyc(5);
		chk("line", 1, fault_wire);
		$display("done faults");
		axr(8'h00, 32'h7, 2'h0);
		axr(8'h00, 32'h0, 2'h0);
		axw(8'h04, 32'h1, 2'h0);
		axr(8'h04, 32'h1, 2'h0);
		overtemp_in <= 1'h1;
		cyc(6);
		chk("irq", 1, irq);
		axr(8'h00, 32'h1, 2'h0);
		cyc(2);
		chk("irq", 0, irq);
		axw(8'h40, 32'h1, 2'h2);
		axr(8'h40, 32'h0, 2'h2);
		overtemp_in <= 1'h0;
		$display("done bus");
		blank_pin <= 1'h0;
		cyc(4);
		blank_pin <= 1'h1;
		n = 0;
		while (!channel_sink[15] && n < 20) begin
			cyc(1);
			n++;
		end
		chk("short", 1, channel_sink[15]);
		$display("done short");
		print_verdict();
	end
	initial begin
		#500000;
		failures++;
		print_verdict();
	end
endmodule
